// ===== shared/msr_consts.svh
/*
 bit positions, reset values and timing counts for the modem status
 registers. assumes inclusion by bare name from shared/.
*/
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH

// ==========================================
// first register: modem interchange signals
`define MSR_SIG_CARRIER 0
`define MSR_SIG_STANDBY 1
`define MSR_SIG_CTS 2
`define MSR_SIG_MODEM_READY 3
`define MSR_SIG_HALF_DUPLEX 4
`define MSR_SIG_RTS 5
`define MSR_SIG_DTR 6
`define MSR_SIG_RING 7

// ==========================================
// second register: line unit maintenance state
`define MSR_MNT_MODE 0
`define MSR_MNT_CLOCK 1
`define MSR_MNT_TEST 2
`define MSR_MNT_RX_ACCEPT 3
`define MSR_MNT_TX_VALID 4
`define MSR_MNT_TX_BIT 5
`define MSR_MNT_QUALITY 6
`define MSR_MNT_RATE 7

// ==========================================
// reset values and timing
`define MSR_MODE_RESET 1'h1
`define MSR_SIG_RESET 8'h00
`define MSR_MNT_RESET 8'h01
`define MSR_CLK_PERIOD_NS 4
`define MSR_MAINT_CLK_HZ 24000
`define MSR_SYS_CLK_HZ 250000000
// half period of maintenance clock, rounded down
`define MSR_MAINT_HALF_CYC (`MSR_SYS_CLK_HZ / (2 * `MSR_MAINT_CLK_HZ))

`endif

// ===== shared/msr_pkg.sv
/*
 types for the modem status registers.
 assumes nothing beyond a systemverilog compiler.
*/
package msr_pkg;

   typedef enum logic [1:0] {
      MSR_TX_IDLE,
      MSR_TX_WAIT_CTS,
      MSR_TX_SEND,
      MSR_TX_DRAIN
   } msr_tx_state_type;

   typedef struct packed {
      msr_tx_state_type tx;
      logic [7:0] sig;
      logic [7:0] mnt;
      logic mode;
      logic maint_clk;
      logic [15:0] div;
      logic [7:0] byte4;
      logic [7:0] byte5;
      logic resp_valid;
   } msr_state_type;

   typedef struct packed {
      logic [1:0] s0;
      logic [1:0] s1;
   } msr_sync_state_type;

endpackage

// ===== src/msr_status.sv
/*
 modem status registers: captures modem interchange levels and line unit
 maintenance state, keeps the transmit handshake with the modem, and
 answers a read-modem-control request with both registers in host bytes
 four and five.
 assumes a single 250 MHz clock, asynchronous active-low reset, modem
 levels arriving asynchronously, and line unit levels from the same clock.
*/
// Behaviour
// - bit 0 first register: carrier detect
// - bit 1: standby indicator level
// - bit 2: clear to send level
// - bit 3: modem ready, fall flags fault
// - bit 4: half-duplex one, full-duplex zero
// - bit 5: request to send output level
// - raise request to send, await cts, send
// - bit 6: data terminal ready output level
// - bit 7: ring indicator, independent of dtr
// - bit 0 second register: mode, resets one
// - bit 1: maintenance clock state, 24 kHz
// - bit 2: modem test mode indicator
// - bit 3: receive silo can accept
// - bit 4: transmit silo output valid
// - bit 5: current serial transmit bit
// - bit 6: signal quality indicator
// - bit 7: signal rate indicator
// - read command returns bytes four, five
`timescale 1ns/1ns
`include "msr_consts.svh"
module msr_status
   import msr_pkg::*;
#(
   parameter int MAINT_HALF_CYC = `MSR_MAINT_HALF_CYC
)
(
   input wire logic clk,
   input wire logic rst_n,
   // modem interchange inputs, asynchronous
   input wire logic carrier_detect,
   input wire logic standby_ind,
   input wire logic clear_to_send,
   input wire logic modem_ready,
   input wire logic ring_ind,
   input wire logic test_mode_ind,
   input wire logic signal_quality,
   input wire logic signal_rate,
   // line unit state, same clock
   input wire logic half_duplex,
   input wire logic dtr_request,
   input wire logic mode_write,
   input wire logic mode_char,
   input wire logic rx_silo_can_accept,
   input wire logic tx_silo_output_valid,
   input wire logic tx_serial_bit,
   // transmit handshake with the line unit
   input wire logic tx_request,
   input wire logic tx_done,
   output logic tx_enable,
   // modem interchange outputs
   output logic request_to_send,
   output logic data_terminal_ready,
   output logic modem_fault,
   // read modem control command
   input wire logic read_modem_ctrl,
   output logic resp_valid,
   output logic [7:0] host_byte_four,
   output logic [7:0] host_byte_five,
   output logic [7:0] modem_signal_status,
   output logic [7:0] line_unit_maint_status
);

   // ==========================================
   // elaboration check
   initial
   begin
      if (MAINT_HALF_CYC < 1 || MAINT_HALF_CYC > 65535)
      begin
         $error("maintenance clock half period out of range");
      end
   end

   localparam logic [15:0] HALF_LAST = 16'(MAINT_HALF_CYC - 1);

   // ==========================================
   // synchronise modem inputs
   logic [7:0] modem_raw;
   logic [7:0] modem_s;

   assign modem_raw = {signal_rate, signal_quality, test_mode_ind,
                       ring_ind, modem_ready, clear_to_send,
                       standby_ind, carrier_detect};

   msr_sync #(.WIDTH(8)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(modem_raw),
      .sync_out(modem_s)
   );

   logic carrier_s;
   logic standby_s;
   logic cts_s;
   logic ready_s;
   logic ring_s;
   logic test_s;
   logic quality_s;
   logic rate_s;

   assign carrier_s = modem_s[0];
   assign standby_s = modem_s[1];
   assign cts_s = modem_s[2];
   assign ready_s = modem_s[3];
   assign ring_s = modem_s[4];
   assign test_s = modem_s[5];
   assign quality_s = modem_s[6];
   assign rate_s = modem_s[7];

   // ==========================================
   // state
   msr_state_type s_q;
   msr_state_type s_d;
   logic ready_prev_q;
   logic fault_q;

   logic rts;

   function automatic logic rts_of(input msr_tx_state_type st);
      rts_of = (st == MSR_TX_WAIT_CTS) || (st == MSR_TX_SEND);
   endfunction

   assign rts = rts_of(s_q.tx);

   always_comb
   begin
      s_d = s_q;
      s_d.resp_valid = 1'b0;

      // maintenance clock divider
      if (s_q.div == HALF_LAST)
      begin
         s_d.div = 16'h0000;
         s_d.maint_clk = ~s_q.maint_clk;
      end
      else
      begin
         s_d.div = s_q.div + 16'h0001;
      end

      // protocol mode
      if (mode_write)
      begin
         s_d.mode = mode_char;
      end

      // transmit handshake
      unique case (s_q.tx)
         MSR_TX_IDLE:
         begin
            if (tx_request && dtr_request && !(half_duplex && carrier_s))
            begin
               s_d.tx = MSR_TX_WAIT_CTS;
            end
         end
         MSR_TX_WAIT_CTS:
         begin
            if (!tx_request || !dtr_request)
            begin
               s_d.tx = MSR_TX_DRAIN;
            end
            else if (cts_s)
            begin
               s_d.tx = MSR_TX_SEND;
            end
         end
         MSR_TX_SEND:
         begin
            if (tx_done || !dtr_request || !cts_s)
            begin
               s_d.tx = MSR_TX_DRAIN;
            end
         end
         MSR_TX_DRAIN:
         begin
            if (!cts_s)
            begin
               s_d.tx = MSR_TX_IDLE;
            end
         end
      endcase

      // status registers
      s_d.sig[`MSR_SIG_CARRIER] = carrier_s;
      s_d.sig[`MSR_SIG_STANDBY] = standby_s;
      s_d.sig[`MSR_SIG_CTS] = cts_s;
      s_d.sig[`MSR_SIG_MODEM_READY] = ready_s;
      s_d.sig[`MSR_SIG_HALF_DUPLEX] = half_duplex;
      s_d.sig[`MSR_SIG_RTS] = rts;
      s_d.sig[`MSR_SIG_DTR] = dtr_request;
      s_d.sig[`MSR_SIG_RING] = ring_s;

      s_d.mnt[`MSR_MNT_MODE] = s_q.mode;
      s_d.mnt[`MSR_MNT_CLOCK] = s_q.maint_clk;
      s_d.mnt[`MSR_MNT_TEST] = test_s;
      s_d.mnt[`MSR_MNT_RX_ACCEPT] = rx_silo_can_accept;
      s_d.mnt[`MSR_MNT_TX_VALID] = tx_silo_output_valid;
      s_d.mnt[`MSR_MNT_TX_BIT] = tx_serial_bit;
      s_d.mnt[`MSR_MNT_QUALITY] = quality_s;
      s_d.mnt[`MSR_MNT_RATE] = rate_s;

      // information response
      if (read_modem_ctrl)
      begin
         s_d.byte4 = s_q.sig;
         s_d.byte5 = s_q.mnt;
         s_d.resp_valid = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q.tx <= MSR_TX_IDLE;
         s_q.sig <= `MSR_SIG_RESET;
         s_q.mnt <= `MSR_MNT_RESET;
         s_q.mode <= `MSR_MODE_RESET;
         s_q.maint_clk <= 1'b0;
         s_q.div <= 16'h0000;
         s_q.byte4 <= 8'h00;
         s_q.byte5 <= 8'h00;
         s_q.resp_valid <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // modem ready fall detect, sticky until ready returns
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ready_prev_q <= 1'b0;
         fault_q <= 1'b0;
      end
      else
      begin
         ready_prev_q <= ready_s;
         if (ready_prev_q && !ready_s)
         begin
            fault_q <= 1'b1;
         end
         else if (ready_s)
         begin
            fault_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // outputs
   assign tx_enable = (s_q.tx == MSR_TX_SEND) && cts_s;
   assign request_to_send = rts;
   assign data_terminal_ready = dtr_request;
   assign modem_fault = fault_q;
   assign resp_valid = s_q.resp_valid;
   assign host_byte_four = s_q.byte4;
   assign host_byte_five = s_q.byte5;
   assign modem_signal_status = s_q.sig;
   assign line_unit_maint_status = s_q.mnt;

endmodule

// ===== src/msr_sync.sv
/*
 two flip-flop synchroniser for a group of level inputs.
 assumes inputs are asynchronous levels; rst_n asynchronous low.
*/
`timescale 1ns/1ns
module msr_sync
   import msr_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ==========================================
   // check
   initial
   begin
      if (WIDTH < 1)
      begin
         $error("msr_sync width must be at least one");
      end
   end

   // ==========================================
   // two stages, first read only by second
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// ===== tb/msr_modem_model.sv
/*
 modem model: answers request to send with clear to send.
 assumes sampling on falling clock edge.
*/
`timescale 1ns/1ns
module msr_modem_model
#(
   parameter int DLY = 2
)
(
   input wire logic clk,
   input wire logic request_to_send,
   output logic clear_to_send
);
   int cnt = 0;
   initial clear_to_send = 1'b0;
   always @(negedge clk)
   begin
      cnt = (request_to_send != clear_to_send) ? cnt + 1 : 0;
      if (cnt > DLY)
      begin
         clear_to_send = request_to_send;
         cnt = 0;
      end
   end
endmodule

// ===== tb/msr_status_properties.sv
/*
 checker for msr_status port behaviour.
 assumes binding to msr_status, single clock domain.
*/
`timescale 1ns/1ns
module msr_status_properties
   import msr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic carrier_detect,
   input wire logic clear_to_send,
   input wire logic ring_ind,
   input wire logic half_duplex,
   input wire logic rx_silo_can_accept,
   input wire logic dtr_request,
   input wire logic data_terminal_ready,
   input wire logic tx_request,
   input wire logic tx_enable,
   input wire logic request_to_send,
   input wire logic read_modem_ctrl,
   input wire logic resp_valid,
   input wire logic [7:0] host_byte_four,
   input wire logic [7:0] host_byte_five,
   input wire logic [7:0] modem_signal_status,
   input wire logic [7:0] line_unit_maint_status
);
   // ==========================================
   // cycles since reset
   logic [1:0] up_q;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         up_q <= 2'h0;
      else if (up_q != 2'h3)
         up_q <= up_q + 2'h1;
   // ==========================================
   // properties
   AST_CARRIER:
      assert property (up_q == 2'h3 |->
         modem_signal_status[0] == $past(carrier_detect, 3))
      else $error("carrier bit wrong");
   AST_CTS:
      assert property (up_q == 2'h3 |->
         modem_signal_status[2] == $past(clear_to_send, 3))
      else $error("cts bit wrong");
   AST_RING:
      assert property (up_q == 2'h3 |->
         modem_signal_status[7] == $past(ring_ind, 3))
      else $error("ring bit wrong");
   AST_HALF:
      assert property (up_q == 2'h3 |->
         modem_signal_status[4] == $past(half_duplex))
      else $error("half duplex bit wrong");
   AST_RXACC:
      assert property (up_q == 2'h3 |->
         line_unit_maint_status[3] == $past(rx_silo_can_accept))
      else $error("rx accept bit wrong");
   AST_DTR:
      assert property (data_terminal_ready == dtr_request)
      else $error("dtr not followed");
   AST_RESP:
      assert property (read_modem_ctrl |=> resp_valid
         && host_byte_four == $past(modem_signal_status)
         && host_byte_five == $past(line_unit_maint_status))
      else $error("read response wrong");
   AST_PULSE:
      assert property (!read_modem_ctrl |=> !resp_valid)
      else $error("stray response");
   AST_TXEN:
      assert property (tx_enable |-> request_to_send)
      else $error("send without rts");
   AST_RTS_UP:
      assert property ($rose(request_to_send) |->
         $past(tx_request && dtr_request))
      else $error("rts without request");
   cover property (read_modem_ctrl ##1 resp_valid);
   cover property ($rose(tx_enable));
   cover property ($rose(modem_signal_status[0]));
endmodule

bind msr_status msr_status_properties chk_u (.clk, .rst_n,
   .carrier_detect, .clear_to_send, .ring_ind, .half_duplex,
   .rx_silo_can_accept, .dtr_request, .data_terminal_ready,
   .tx_request, .tx_enable, .request_to_send, .read_modem_ctrl,
   .resp_valid, .host_byte_four, .host_byte_five,
   .modem_signal_status, .line_unit_maint_status);

// ===== tb/testbench.sv
/*
 directed testbench for msr_status.
 assumes msr_modem_model drives clear to send.
*/
`timescale 1ns/1ns
module testbench import msr_pkg::*;;
   logic clk = 0;
   logic rst_n = 0;
   logic [10:0] m = '0;
   logic dtr = 0, mw = 0, mc = 0, txr = 0, txd = 0, rd = 0;
   logic cts, ten, rts, dtro, flt, rv;
   logic [7:0] b4, b5, ms, ls;
   int err_count = 0;
   int checked = 0;
   always #2 clk = ~clk;
   msr_modem_model mdm_u (.clk, .request_to_send(rts),
      .clear_to_send(cts));
   msr_status #(.MAINT_HALF_CYC(4)) dut_u (.clk, .rst_n,
      .carrier_detect(m[0]), .standby_ind(m[1]), .clear_to_send(cts),
      .modem_ready(m[2]), .ring_ind(m[3]), .test_mode_ind(m[4]),
      .signal_quality(m[5]), .signal_rate(m[6]), .half_duplex(m[10]),
      .dtr_request(dtr), .mode_write(mw), .mode_char(mc),
      .rx_silo_can_accept(m[7]), .tx_silo_output_valid(m[8]),
      .tx_serial_bit(m[9]), .tx_request(txr), .tx_done(txd),
      .tx_enable(ten), .request_to_send(rts),
      .data_terminal_ready(dtro), .modem_fault(flt),
      .read_modem_ctrl(rd), .resp_valid(rv), .host_byte_four(b4),
      .host_byte_five(b5), .modem_signal_status(ms),
      .line_unit_maint_status(ls));
   // ==========================================
   // helpers
   task cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(logic [7:0] got, logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task t_reset;
      chk(ms, 8'h00);
      chk(ls, 8'h01);
      chk({7'h0, rts}, 8'h00);
   endtask
   task t_levels;
      int pos[11] = '{8, 9, 11, 15, 2, 6, 7, 3, 4, 5, 12};
      logic [15:0] e;
      for (int i = 0; i < 11; i++)
      begin
         m = 11'h1 << i;
         e = 16'h1 << pos[i];
         cyc(4);
         chk(ms & 8'h9b, e[15:8]);
         chk(ls & 8'hfc, e[7:0]);
      end
      m = '0;
   endtask
   task t_clk;
      logic v;
      int n;
      for (int k = 0; k < 2; k++)
      begin
         v = ls[1];
         n = 0;
         while (ls[1] === v && n < 20)
         begin
            cyc(1);
            n++;
         end
      end
      chk(n[7:0], 8'h04);
   endtask
   task t_mode;
      for (int k = 0; k < 2; k++)
      begin
         mc = k[0];
         mw = 1;
         cyc(1);
         mw = 0;
         cyc(3);
         chk({7'h0, ls[0]}, {7'h0, k[0]});
      end
   endtask
   task t_read;
      m = 11'h0a1;
      cyc(4);
      rd = 1;
      cyc(2);
      chk({7'h0, rv}, 8'h01);
      chk(b4, 8'h01);
      chk(b5 & 8'hfd, 8'h49);
      rd = 0;
      cyc(1);
      chk({7'h0, rv}, 8'h00);
      m = '0;
   endtask
   task t_fault;
      m = 11'h004;
      cyc(5);
      m = '0;
      cyc(5);
      chk({7'h0, flt}, 8'h01);
      m = 11'h004;
      cyc(5);
      chk({7'h0, flt}, 8'h00);
   endtask
   task t_tx;
      int n;
      dtr = 1;
      m = 11'h405;
      cyc(4);
      txr = 1;
      cyc(10);
      chk({7'h0, rts}, 8'h00);
      txr = 0;
      m = 11'h004;
      cyc(2);
      txr = 1;
      n = 0;
      while (ten !== 1'b1 && n < 30)
      begin
         cyc(1);
         n++;
      end
      chk({3'h0, rts, cts, dtro, ms[6:5]}, 8'h1f);
      txd = 1;
      txr = 0;
      cyc(1);
      txd = 0;
      chk({6'h0, rts, ten}, 8'h00);
      cyc(12);
      chk({6'h0, cts, ms[5]}, 8'h00);
   endtask
   // ==========================================
   // main sequence and watchdog
   initial
   begin
      cyc(8);
      t_reset;
      rst_n = 1;
      t_levels;
      t_clk;
      t_mode;
      t_read;
      t_fault;
      t_tx;
      close_out;
   end
   initial
   begin
      #20000;
      err_count++;
      close_out;
   end
endmodule
